// ---- gppb_consts.svh ----
`ifndef GPPB_CONSTS_SVH
`define GPPB_CONSTS_SVH

// port width and bus widths
`define GPPB_WIDTH        8
`define GPPB_AW           12
`define GPPB_DW           32

// register byte offsets
`define GPPB_OFF_DATA_LO  12'h000
`define GPPB_OFF_DATA_HI  12'h3fc
`define GPPB_OFF_DIR      12'h400
`define GPPB_OFF_FR1      12'h424
`define GPPB_OFF_FR2      12'h428
`define GPPB_OFF_IS       12'h804
`define GPPB_OFF_IBE      12'h808
`define GPPB_OFF_IEV      12'h80c
`define GPPB_OFF_IE       12'h810
`define GPPB_OFF_RIS      12'h814
`define GPPB_OFF_MIS      12'h818
`define GPPB_OFF_IC       12'h81c
`define GPPB_OFF_ODE      12'hc00

// data register bit-mask field inside the address
`define GPPB_BM_LSB       2
`define GPPB_BM_MSB       9

// reset values, default write mask and zero constants
`define GPPB_RST_DATA     8'hff
`define GPPB_RST_DIR      8'h00
`define GPPB_RST_FR1      8'h00
`define GPPB_RST_FR2      8'h00
`define GPPB_RST_IRQ      8'h00
`define GPPB_RST_ODE      8'h00
`define GPPB_ALL_WRITABLE 8'hff
`define GPPB_ZERO8        8'h00
`define GPPB_ZERO32       32'h0000_0000

`endif

// ---- gppb_irq_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "gppb_consts.svh"

module gppb_irq_detect #(
   parameter int WIDTH = `GPPB_WIDTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   input  wire logic [WIDTH-1:0] level_sel_i,
   input  wire logic [WIDTH-1:0] both_sel_i,
   input  wire logic [WIDTH-1:0] high_sel_i,
   input  wire logic [WIDTH-1:0] clear_i,
   output logic      [WIDTH-1:0] raw_o
);
   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] edge_pend_r;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] fall;
   logic [WIDTH-1:0] edge_hit;

   // previous pin sample for edge detection
   // tracks the pin during reset, so no false edge on release
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         prev_r <= pin_i;
      else
         prev_r <= pin_i;
   end

   assign rise     = pin_i & ~prev_r;
   assign fall     = ~pin_i & prev_r;
   assign edge_hit = ~level_sel_i & ((both_sel_i & (rise | fall))
                   | (~both_sel_i & high_sel_i & rise)
                   | (~both_sel_i & ~high_sel_i & fall));

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         edge_pend_r <= '0;
      else
         edge_pend_r <= edge_hit | (edge_pend_r & ~clear_i);
   end

   assign raw_o = (level_sel_i & ~(pin_i ^ high_sel_i)) | (~level_sel_i & edge_pend_r);

   property p_both_edges;
      @(posedge clk_i) disable iff (rst_i)
      (!level_sel_i[0] && both_sel_i[0] && (pin_i[0] != prev_r[0])) |=> raw_o[0] || level_sel_i[0];
   endproperty
   a_both_edges: assert property (p_both_edges)
      else $error("both-edge event not latched");

   property p_single_edge;
      @(posedge clk_i) disable iff (rst_i)
      (!level_sel_i[0] && !both_sel_i[0] && high_sel_i[0] && fall[0] && !edge_pend_r[0])
         |=> !edge_pend_r[0];
   endproperty
   a_single_edge: assert property (p_single_edge)
      else $error("wrong edge latched");

   property p_clear;
      @(posedge clk_i) disable iff (rst_i)
      (clear_i[0] && !edge_hit[0]) |=> !edge_pend_r[0];
   endproperty
   a_clear: assert property (p_clear)
      else $error("pending edge not cleared");

endmodule // gppb_irq_detect
`default_nettype wire

// ---- gppb_pin_mux.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "gppb_consts.svh"

module gppb_pin_mux
   import gppb_pkg::*;
#(
   parameter int WIDTH = `GPPB_WIDTH
) (
   input  wire logic             [WIDTH-1:0] data_i,
   input  wire logic             [WIDTH-1:0] dir_i,
   input  wire logic             [WIDTH-1:0] fr1_i,
   input  wire logic             [WIDTH-1:0] fr2_i,
   input  wire logic             [WIDTH-1:0] ode_i,
   input  wire gppb_pkg::gppb_alt_t          alt1_i,
   input  wire gppb_pkg::gppb_alt_t          alt2_i,
   output logic                  [WIDTH-1:0] pad_o,
   output logic                  [WIDTH-1:0] pad_oe_o
);
   logic [WIDTH-1:0] val;
   logic [WIDTH-1:0] drv;

   always_comb
   begin
      val = data_i;
      drv = dir_i;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (fr1_i[i])
         begin
            val[i] = alt1_i.out[i];
            drv[i] = alt1_i.oe[i];
         end
         else if (fr2_i[i])
         begin
            val[i] = alt2_i.out[i];
            drv[i] = alt2_i.oe[i];
         end
      end
   end

   // open drain drives low only
   assign pad_o    = val & ~ode_i;
   assign pad_oe_o = drv & ~(ode_i & val);

endmodule // gppb_pin_mux
`default_nettype wire

// ---- gppb_pkg.sv ----
`default_nettype none
`include "gppb_consts.svh"

package gppb_pkg;

   // register selected by an address
   typedef enum logic [3:0] {
      GPPB_REG_DATA,
      GPPB_REG_DIR,
      GPPB_REG_FR1,
      GPPB_REG_FR2,
      GPPB_REG_IS,
      GPPB_REG_IBE,
      GPPB_REG_IEV,
      GPPB_REG_IE,
      GPPB_REG_RIS,
      GPPB_REG_MIS,
      GPPB_REG_IC,
      GPPB_REG_ODE,
      GPPB_REG_NONE
   } gppb_reg_t;

   // classic wishbone request from the master
   typedef struct packed {
      logic                   cyc;
      logic                   stb;
      logic                   we;
      logic [3:0]             sel;
      logic [`GPPB_AW-1:0]    adr;
      logic [`GPPB_DW-1:0]    dat;
   } gppb_wb_req_t;

   // one alternate peripheral's drive of the port
   typedef struct packed {
      logic [`GPPB_WIDTH-1:0] out;
      logic [`GPPB_WIDTH-1:0] oe;
   } gppb_alt_t;

endpackage
`default_nettype wire

// ---- gppb_port_bank.sv ----
// Operation
// - both-edges select fires on either transition
// - raw pending status readable, resets zero
// - non-writable bits ignore bus writes
// - function select routes peripheral output and enable to pin
`timescale 1ns/100ps
`default_nettype none
`include "gppb_consts.svh"

module gppb_port_bank
   import gppb_pkg::*;
#(
   parameter int                    WIDTH      = `GPPB_WIDTH,
   parameter logic [`GPPB_WIDTH-1:0] DATA_RST   = `GPPB_RST_DATA,
   parameter logic [`GPPB_WIDTH-1:0] DIR_RST    = `GPPB_RST_DIR,
   parameter logic [`GPPB_WIDTH-1:0] FR1_RST    = `GPPB_RST_FR1,
   parameter logic [`GPPB_WIDTH-1:0] DATA_WMASK = `GPPB_ALL_WRITABLE,
   parameter logic [`GPPB_WIDTH-1:0] DIR_WMASK  = `GPPB_ALL_WRITABLE,
   parameter logic [`GPPB_WIDTH-1:0] FR1_WMASK  = `GPPB_ALL_WRITABLE,
   parameter logic [`GPPB_WIDTH-1:0] FR2_WMASK  = `GPPB_ALL_WRITABLE,
   parameter logic [`GPPB_WIDTH-1:0] IRQ_WMASK  = `GPPB_ALL_WRITABLE,
   parameter logic [`GPPB_WIDTH-1:0] ODE_WMASK  = `GPPB_ALL_WRITABLE
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire gppb_pkg::gppb_wb_req_t        wb_req_i,
   output logic                  [`GPPB_DW-1:0] wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic             [WIDTH-1:0]  general_port_pin_i,
   output logic                  [WIDTH-1:0]  general_port_pin_o,
   output logic                  [WIDTH-1:0]  general_port_pin_oe_o,
   input  wire gppb_pkg::gppb_alt_t           alt1_i,
   input  wire gppb_pkg::gppb_alt_t           alt2_i,
   output logic                  [WIDTH-1:0]  alt_in_o,
   output logic                               irq_o
);
   logic [WIDTH-1:0]    port_data_masked_r;
   logic [WIDTH-1:0]    pin_direction_r;
   logic [WIDTH-1:0]    alt_function_select_one_r;
   logic [WIDTH-1:0]    alt_function_select_two_r;
   logic [WIDTH-1:0]    irq_edge_or_level_r;
   logic [WIDTH-1:0]    irq_both_edges_r;
   logic [WIDTH-1:0]    irq_polarity_r;
   logic [WIDTH-1:0]    irq_enable_mask_r;
   logic [WIDTH-1:0]    open_drain_enable_r;
   logic [WIDTH-1:0]    irq_raw_pending;
   logic [WIDTH-1:0]    irq_masked_pending;
   logic [WIDTH-1:0]    irq_clear_nxt;
   logic [WIDTH-1:0]    data_view;
   logic [WIDTH-1:0]    bit_mask;
   logic [WIDTH-1:0]    wr_byte;
   logic [WIDTH-1:0]    rd_byte;
   logic [WIDTH-1:0]    pad_nxt;
   logic [WIDTH-1:0]    pad_oe_nxt;
   logic                ack_r;
   logic                req;
   logic                wr;
   logic                wr_lane;
   gppb_reg_t           sel_reg;

   // map a byte address to a register
   function automatic gppb_reg_t decode(input logic [`GPPB_AW-1:0] adr);
      gppb_reg_t r;
      r = GPPB_REG_NONE;
      if (adr[1:0] == 2'b00)
      begin
         if (adr <= `GPPB_OFF_DATA_HI)
            r = GPPB_REG_DATA;
         else
         begin
            case (adr)
               `GPPB_OFF_DIR: r = GPPB_REG_DIR;
               `GPPB_OFF_FR1: r = GPPB_REG_FR1;
               `GPPB_OFF_FR2: r = GPPB_REG_FR2;
               `GPPB_OFF_IS:  r = GPPB_REG_IS;
               `GPPB_OFF_IBE: r = GPPB_REG_IBE;
               `GPPB_OFF_IEV: r = GPPB_REG_IEV;
               `GPPB_OFF_IE:  r = GPPB_REG_IE;
               `GPPB_OFF_RIS: r = GPPB_REG_RIS;
               `GPPB_OFF_MIS: r = GPPB_REG_MIS;
               `GPPB_OFF_IC:  r = GPPB_REG_IC;
               `GPPB_OFF_ODE: r = GPPB_REG_ODE;
               default:       r = GPPB_REG_NONE;
            endcase
         end
      end
      return r;
   endfunction

   // merge write data into writable bits only
   function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old,
                                              input logic [WIDTH-1:0] nw,
                                              input logic [WIDTH-1:0] wmask);
      return (old & ~wmask) | (nw & wmask);
   endfunction

   // bus request qualification
   assign req      = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
   assign wr       = req & wb_req_i.we;
   assign wr_lane  = wr & wb_req_i.sel[0];
   assign wr_byte  = wb_req_i.dat[WIDTH-1:0];
   assign sel_reg  = decode(wb_req_i.adr);
   assign bit_mask = wb_req_i.adr[`GPPB_BM_MSB:`GPPB_BM_LSB];

   // one-cycle ack, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_r <= 1'b0;
      else
         ack_r <= req;
   end

   // data register, masked by address bits
   // locked data bits kept
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         port_data_masked_r <= DATA_RST;
      else if (wr_lane && sel_reg == GPPB_REG_DATA)
         port_data_masked_r <= merge(port_data_masked_r, wr_byte, bit_mask & DATA_WMASK);
   end

   // direction, function selects and open drain enable
   // locked control bits kept
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_direction_r           <= DIR_RST;
         alt_function_select_one_r <= FR1_RST;
         alt_function_select_two_r <= `GPPB_RST_FR2;
         open_drain_enable_r       <= `GPPB_RST_ODE;
      end
      else if (wr_lane)
      begin
         case (sel_reg)
            GPPB_REG_DIR:
               pin_direction_r <= merge(pin_direction_r, wr_byte, DIR_WMASK);
            GPPB_REG_FR1:
               alt_function_select_one_r <= merge(alt_function_select_one_r, wr_byte,
                                                  FR1_WMASK);
            GPPB_REG_FR2:
               alt_function_select_two_r <= merge(alt_function_select_two_r, wr_byte,
                                                  FR2_WMASK);
            GPPB_REG_ODE:
               open_drain_enable_r <= merge(open_drain_enable_r, wr_byte, ODE_WMASK);
            default:
               open_drain_enable_r <= open_drain_enable_r;
         endcase
      end
   end

   // interrupt configuration registers
   // locked interrupt bits kept
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_edge_or_level_r <= `GPPB_RST_IRQ;
         irq_both_edges_r    <= `GPPB_RST_IRQ;
         irq_polarity_r      <= `GPPB_RST_IRQ;
         irq_enable_mask_r   <= `GPPB_RST_IRQ;
      end
      else if (wr_lane)
      begin
         case (sel_reg)
            GPPB_REG_IS:
               irq_edge_or_level_r <= merge(irq_edge_or_level_r, wr_byte, IRQ_WMASK);
            GPPB_REG_IBE:
               irq_both_edges_r <= merge(irq_both_edges_r, wr_byte, IRQ_WMASK);
            GPPB_REG_IEV:
               irq_polarity_r <= merge(irq_polarity_r, wr_byte, IRQ_WMASK);
            GPPB_REG_IE:
               irq_enable_mask_r <= merge(irq_enable_mask_r, wr_byte, IRQ_WMASK);
            default:
               irq_enable_mask_r <= irq_enable_mask_r;
         endcase
      end
   end

   assign irq_clear_nxt = (wr_lane && sel_reg == GPPB_REG_IC) ? (wr_byte & IRQ_WMASK)
                                                               : `GPPB_ZERO8;

   // per-bit event detection
   gppb_irq_detect #(
      .WIDTH       (WIDTH)
   ) u_detect (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .pin_i       (general_port_pin_i),
      .level_sel_i (irq_edge_or_level_r),
      .both_sel_i  (irq_both_edges_r),
      .high_sel_i  (irq_polarity_r),
      .clear_i     (irq_clear_nxt),
      .raw_o       (irq_raw_pending)
   );

   assign irq_masked_pending = irq_raw_pending & irq_enable_mask_r;

   // interrupt request line
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |irq_masked_pending;
   end

   // pin view: outputs read latch, inputs read pin
   assign data_view = (pin_direction_r & port_data_masked_r)
                    | (~pin_direction_r & general_port_pin_i);

   // read mux
   // raw status read
   always_comb
   begin
      case (sel_reg)
         GPPB_REG_DATA: rd_byte = data_view & bit_mask;
         GPPB_REG_DIR:  rd_byte = pin_direction_r;
         GPPB_REG_FR1:  rd_byte = alt_function_select_one_r;
         GPPB_REG_FR2:  rd_byte = alt_function_select_two_r;
         GPPB_REG_IS:   rd_byte = irq_edge_or_level_r;
         GPPB_REG_IBE:  rd_byte = irq_both_edges_r;
         GPPB_REG_IEV:  rd_byte = irq_polarity_r;
         GPPB_REG_IE:   rd_byte = irq_enable_mask_r;
         GPPB_REG_RIS:  rd_byte = irq_raw_pending;
         GPPB_REG_MIS:  rd_byte = irq_masked_pending;
         GPPB_REG_ODE:  rd_byte = open_drain_enable_r;
         default:       rd_byte = `GPPB_ZERO8;
      endcase
   end

   // read data latched with the ack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= `GPPB_ZERO32;
      else if (req && !wb_req_i.we)
         wb_dat_o <= {{(`GPPB_DW-WIDTH){1'b0}}, rd_byte};
   end

   assign wb_ack_o = ack_r;

   // pad drive selection
   gppb_pin_mux #(
      .WIDTH    (WIDTH)
   ) u_mux (
      .data_i   (port_data_masked_r),
      .dir_i    (pin_direction_r),
      .fr1_i    (alt_function_select_one_r),
      .fr2_i    (alt_function_select_two_r),
      .ode_i    (open_drain_enable_r),
      .alt1_i   (alt1_i),
      .alt2_i   (alt2_i),
      .pad_o    (pad_nxt),
      .pad_oe_o (pad_oe_nxt)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         general_port_pin_o    <= '0;
         general_port_pin_oe_o <= '0;
         alt_in_o              <= '0;
      end
      else
      begin
         general_port_pin_o    <= pad_nxt;
         general_port_pin_oe_o <= pad_oe_nxt;
         alt_in_o              <= general_port_pin_i;
      end
   end

   property p_raw_reset;
      @(posedge clk_i)
      rst_i |=> (irq_raw_pending & ~irq_edge_or_level_r) == `GPPB_ZERO8;
   endproperty
   a_raw_reset: assert property (p_raw_reset)
      else $error("raw edge status not zero after reset");

   property p_locked_dir;
      @(posedge clk_i) disable iff (rst_i)
      (wr_lane && sel_reg == GPPB_REG_DIR)
         |=> ((pin_direction_r ^ $past(pin_direction_r)) & ~DIR_WMASK) == `GPPB_ZERO8;
   endproperty
   a_locked_dir: assert property (p_locked_dir)
      else $error("locked direction bit changed");

   property p_locked_fr2;
      @(posedge clk_i) disable iff (rst_i)
      (wr_lane && sel_reg == GPPB_REG_FR2)
         |=> ((alt_function_select_two_r ^ $past(alt_function_select_two_r)) & ~FR2_WMASK)
             == `GPPB_ZERO8;
   endproperty
   a_locked_fr2: assert property (p_locked_fr2)
      else $error("locked function select bit changed");

   property p_gpio_out;
      @(posedge clk_i) disable iff (rst_i)
      (!alt_function_select_one_r[0] && !alt_function_select_two_r[0]
         && pin_direction_r[0] && !open_drain_enable_r[0])
         |=> general_port_pin_oe_o[0] && (general_port_pin_o[0] == $past(port_data_masked_r[0]));
   endproperty
   a_gpio_out: assert property (p_gpio_out)
      else $error("gpio output not driven from data");

   property p_alt_out;
      @(posedge clk_i) disable iff (rst_i)
      (alt_function_select_one_r[0] && !open_drain_enable_r[0])
         |=> general_port_pin_o[0] == $past(alt1_i.out[0])
             && general_port_pin_oe_o[0] == $past(alt1_i.oe[0]);
   endproperty
   a_alt_out: assert property (p_alt_out)
      else $error("alternate function not routed");

   property p_masked_read;
      @(posedge clk_i) disable iff (rst_i)
      (req && !wb_req_i.we && sel_reg == GPPB_REG_MIS)
         |=> wb_ack_o
             && wb_dat_o[WIDTH-1:0] == ($past(irq_raw_pending) & $past(irq_enable_mask_r));
   endproperty
   a_masked_read: assert property (p_masked_read)
      else $error("masked status read mismatch");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

endmodule // gppb_port_bank
`default_nettype wire

// ---- tb_gppb_port_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "gppb_consts.svh"

// compare two values, count and report a mismatch
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end

module tb_gppb_port_bank;
   import gppb_pkg::*;

   logic         clk_i       = 1'b0;
   logic         rst_i       = 1'b1;
   gppb_wb_req_t req         = '0;
   logic [31:0]  wb_dat;
   logic         wb_ack;
   logic [7:0]   pins        = 8'h00;
   logic [7:0]   pin_o;
   logic [7:0]   pin_oe;
   logic [7:0]   alt_in;
   gppb_alt_t    alt1        = '0;
   gppb_alt_t    alt2        = '0;
   logic         irq;
   logic [31:0]  rd;
   int           miscompares = 0;
   int           checks_done = 0;
   int           cycles      = 0;
   logic [11:0]  offs [12]   = '{`GPPB_OFF_DIR, `GPPB_OFF_FR1, `GPPB_OFF_FR2, `GPPB_OFF_IS,
                                 `GPPB_OFF_IBE, `GPPB_OFF_IEV, `GPPB_OFF_IE, `GPPB_OFF_ODE,
                                 `GPPB_OFF_RIS, `GPPB_OFF_MIS, `GPPB_OFF_IC, 12'h900};

   // device under test, upper nibble of the second function select locked
   gppb_port_bank #(
      .FR2_WMASK (8'h0f)
   ) dut (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .wb_req_i              (req),
      .wb_dat_o              (wb_dat),
      .wb_ack_o              (wb_ack),
      .general_port_pin_i    (pins),
      .general_port_pin_o    (pin_o),
      .general_port_pin_oe_o (pin_oe),
      .alt1_i                (alt1),
      .alt2_i                (alt2),
      .alt_in_o              (alt_in),
      .irq_o                 (irq)
   );

   // 20 MHz clock
   always #25 clk_i = ~clk_i;

   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         $display("Error at %0t: run timed out", $time);
         finish_test();
      end
   end

   // one classic bus cycle, held until ack is sampled high
   task automatic xfer(input logic [11:0] a, input logic w, input logic [3:0] s,
                       input logic [31:0] d);
      int n;
      req.cyc <= 1'b1;
      req.stb <= 1'b1;
      req.we  <= w;
      req.sel <= s;
      req.adr <= a;
      req.dat <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 100);
      if (wb_ack !== 1'b1)
      begin
         miscompares++;
         $display("Error at %0t: no bus answer", $time);
      end
      rd = wb_dat;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      req.we  <= 1'b0;
      @(posedge clk_i);
   endtask

   // byte write in lane 0
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(a, 1'b1, 4'h1, {24'h00_0000, d});
   endtask

   // read and compare, upper bits zero
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 4'hf, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, e})
   endtask

   // let pin sampling and output registers catch up
   task automatic settle();
      repeat (4) @(posedge clk_i);
   endtask

   // main sequence
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values, unmapped address reads zero
      for (int i = 0; i < 12; i++)
         rdchk(offs[i], 8'h00);
      `CHK(pin_oe, 8'h00)
      wr(`GPPB_OFF_DIR, 8'hff);
      rdchk(`GPPB_OFF_DATA_HI, 8'hff);
      // writable registers read back, locked bits and status stay put
      for (int i = 0; i < 8; i++)
      begin
         wr(offs[i], 8'ha5);
         rdchk(offs[i], (i == 2) ? 8'h05 : 8'ha5);
         wr(offs[i], 8'h00);
      end
      wr(`GPPB_OFF_RIS, 8'hff);
      rdchk(`GPPB_OFF_RIS, 8'h00);
      wr(`GPPB_OFF_DIR, 8'h3c);
      xfer(`GPPB_OFF_DIR, 1'b1, 4'he, 32'h0000_00ff);
      rdchk(`GPPB_OFF_DIR, 8'h3c);
      // masked data access as outputs
      wr(`GPPB_OFF_DIR, 8'hff);
      wr(`GPPB_OFF_DATA_HI, 8'h00);
      wr(12'h0e8, 8'h93);
      rdchk(`GPPB_OFF_DATA_HI, 8'h12);
      rdchk(12'h0e8, 8'h12);
      rdchk(`GPPB_OFF_DATA_LO, 8'h00);
      settle();
      `CHK(pin_o, 8'h12)
      `CHK(pin_oe, 8'hff)
      // mixed direction, input half reads the pins
      wr(`GPPB_OFF_DIR, 8'h0f);
      pins <= 8'ha0;
      settle();
      rdchk(`GPPB_OFF_DATA_HI, 8'ha2);
      `CHK(alt_in, 8'ha0)
      // alternate functions take over selected bits
      alt1 <= '{out: 8'h01, oe: 8'h03};
      alt2 <= '{out: 8'h04, oe: 8'h04};
      wr(`GPPB_OFF_FR1, 8'h03);
      wr(`GPPB_OFF_FR2, 8'h04);
      settle();
      `CHK(pin_oe, 8'h0f)
      `CHK(pin_o & pin_oe, 8'h05)
      // open drain on bit 3
      wr(`GPPB_OFF_FR1, 8'h00);
      wr(`GPPB_OFF_FR2, 8'h00);
      wr(`GPPB_OFF_ODE, 8'h08);
      wr(`GPPB_OFF_DATA_HI, 8'h00);
      settle();
      `CHK(pin_oe, 8'h0f)
      wr(`GPPB_OFF_DATA_HI, 8'h08);
      settle();
      `CHK(pin_oe, 8'h07)
      `CHK(pin_o & pin_oe, 8'h00)
      // interrupts: b0 rise, b1 fall, b2 both, b3 level high, b4 level low
      wr(`GPPB_OFF_ODE, 8'h00);
      wr(`GPPB_OFF_DIR, 8'h00);
      pins <= 8'h00;
      settle();
      wr(`GPPB_OFF_IE, 8'h05);
      wr(`GPPB_OFF_IEV, 8'h09);
      wr(`GPPB_OFF_IBE, 8'h04);
      wr(`GPPB_OFF_IS, 8'h18);
      wr(`GPPB_OFF_IC, 8'hff);
      rdchk(`GPPB_OFF_RIS, 8'h10);
      rdchk(`GPPB_OFF_MIS, 8'h00);
      `CHK(irq, 1'b0)
      pins <= 8'h1f;
      settle();
      rdchk(`GPPB_OFF_RIS, 8'h0d);
      rdchk(`GPPB_OFF_MIS, 8'h05);
      `CHK(irq, 1'b1)
      wr(`GPPB_OFF_IC, 8'h01);
      rdchk(`GPPB_OFF_RIS, 8'h0c);
      wr(`GPPB_OFF_IC, 8'h00);
      rdchk(`GPPB_OFF_RIS, 8'h0c);
      pins <= 8'h00;
      settle();
      rdchk(`GPPB_OFF_RIS, 8'h16);
      rdchk(`GPPB_OFF_MIS, 8'h04);
      wr(`GPPB_OFF_IC, 8'hff);
      rdchk(`GPPB_OFF_RIS, 8'h10);
      settle();
      `CHK(irq, 1'b0)
      wr(`GPPB_OFF_IE, 8'h10);
      settle();
      `CHK(irq, 1'b1)
      rdchk(`GPPB_OFF_MIS, 8'h10);
      // mid-run reset clears pending edges and config
      pins <= 8'h04;
      settle();
      rdchk(`GPPB_OFF_RIS, 8'h14);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdchk(`GPPB_OFF_RIS, 8'h00);
      rdchk(`GPPB_OFF_DATA_HI, 8'h04);
      `CHK(irq, 1'b0)
      finish_test();
   end

endmodule // tb_gppb_port_bank

`default_nettype wire
